// *** verilog/bcm_pkg.sv ***
// ****************************************************************
// shared constants of the background configuration crc monitor
// ****************************************************************
package bcm_pkg;

  // crc arithmetic
  localparam int CRC_W = 32;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // frame geometry of the masking scheme
  localparam int FRAME_CLBS = 16;
  localparam int FRAME_LUTS = 64;
  localparam int IO_ADJ_CLBS = 14;
  localparam int IODRP_FRAMES = 1;
  localparam int COMBINED_FRAMES = 5;

  // internal oscillator divider width
  localparam int OSC_DIV_W = 8;

  // option encodings
  localparam logic OPT_ENABLE = 1'b1;
  localparam logic OPT_DISABLE = 1'b0;
  localparam logic ACT_HALT = 1'b0;
  localparam logic ACT_CONTINUE = 1'b1;
  localparam logic SRC_PRE_COMPUTED = 1'b0;
  localparam logic SRC_FIRST_READBACK = 1'b1;

  // class of each readback word
  typedef enum logic [2:0] {
    KIND_LUT = 3'h0,
    KIND_IO = 3'h1,
    KIND_BRAM = 3'h2,
    KIND_PLL = 3'h3,
    KIND_OTHER = 3'h4
  } bcm_kind_t;

  // checker states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SCAN = 4'h2,
    ST_CHECK = 4'h4,
    ST_HOLD = 4'h8
  } bcm_state_t;

endpackage

// *** verilog/bcm_crc_if.sv ***
`timescale 1ns/1ps
// ****************************************************************
// link between checker control and crc accumulator
// ****************************************************************
interface bcm_crc_if #(
  parameter int DW = 32
);
  import bcm_pkg::*;
  logic start;
  logic step;
  logic [DW-1:0] data;
  logic [CRC_W-1:0] crc;

  modport ctrl (output start, output step, output data, input crc);
  modport eng (input start, input step, input data, output crc);
endinterface

// *** verilog/bcm_crc_engine.sv ***
`timescale 1ns/1ps
// ****************************************************************
// crc accumulator, one data word per step
// ****************************************************************
module bcm_crc_engine #(
  parameter int DW = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // accumulator link
  bcm_crc_if.eng ifc
);
  import bcm_pkg::*;

  // msb-first serial crc unrolled over the whole word
  function automatic logic [CRC_W-1:0] crc_next(
    input logic [CRC_W-1:0] c,
    input logic [DW-1:0] d
  );
    logic [CRC_W-1:0] r;
    logic fb;
    r = c;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = r[CRC_W-1] ^ d[i];
      r = {r[CRC_W-2:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // start wins over step so every scan begins from the seed
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ifc.crc <= CRC_INIT;
    end else if (ce) begin
      if (ifc.start) begin
        ifc.crc <= CRC_INIT;
      end else if (ifc.step) begin
        ifc.crc <= crc_next(ifc.crc, ifc.data);
      end
    end
  end

endmodule

// *** verilog/bcm_monitor.sv ***
`timescale 1ns/1ps
// Contract
// - continuously read back memory, crc per scan
// - compare each scan crc with golden value
// - mismatch raises flag, pulls init pin low
// - init pin flag can be disabled
// - mismatch flag sticky until cleared
// - halt events stop checking, clear flag
// - halting never disturbs user configuration access
// - after halt, reload golden, resume if enabled
// - run only after done pin high
// - no run while jtag holds config instruction
// - lut memory frames exclude lut contents
// - block ram contents never checked
// - pll dynamic port changes never masked
// - io tile drp masks tile and lut frame
// - io drp plus lut memory masks five frames
// - step clock chosen by port and mode
// - jtag preempts checker on configuration bus
// - enable setting turns checking on or off
// - error action halt or continue
// - golden from tools or first readback
module bcm_monitor #(
  parameter int DW = 32,
  parameter int NUM_FRAMES = 64,
  parameter int WORDS = 4
) (
  // clock, reset, clock enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // static options
  input wire logic readback_crc_enable,
  input wire logic init_pin_flag_select,
  input wire logic error_action_select,
  input wire logic golden_source_select,
  input wire logic [bcm_pkg::OSC_DIV_W-1:0] internal_osc_rate_select,
  input wire logic [bcm_pkg::CRC_W-1:0] precomputed_golden,
  // clock source selection
  input wire logic internal_config_port_present,
  input wire logic slave_mode,
  input wire logic internal_config_port_clk_tick,
  input wire logic config_clock_tick,
  // device status and halting events
  input wire logic done_pin,
  input wire logic sync_word_det,
  input wire logic config_release_cmd,
  input wire logic tap_reset,
  input wire logic config_abort,
  input wire logic internal_reprogram_cmd,
  input wire logic suspend_active,
  input wire logic shutdown_active,
  input wire logic jtag_ir_config,
  input wire logic jtag_bus_req,
  input wire logic user_config_busy,
  // masking information
  input wire logic io_drp_top,
  input wire logic io_drp_bottom,
  input wire logic lut_memory_top,
  input wire logic lut_memory_bottom,
  // configuration memory readback port
  output logic rd_req,
  output logic [$clog2(NUM_FRAMES)-1:0] rd_frame,
  output logic [$clog2(WORDS)-1:0] rd_word,
  input wire logic rd_ack,
  input wire logic [DW-1:0] rd_data,
  input wire bcm_pkg::bcm_kind_t rd_kind,
  input wire logic rd_lut_memory_frame,
  // user side
  input wire logic clear_error,
  output logic crc_mismatch_out,
  output logic checker_running,
  output logic init_pin_o,
  output logic init_pin_oe
);
  import bcm_pkg::*;

  localparam int FW = $clog2(NUM_FRAMES);
  localparam int WW = $clog2(WORDS);
  localparam logic [FW-1:0] LAST_FRAME = FW'(NUM_FRAMES - 1);
  localparam logic [WW-1:0] LAST_WORD = WW'(WORDS - 1);

  // ****************************************************************
  // masking decision
  // ****************************************************************

  // lut and io tile words near an edge with io drp are masked; the
  // window grows to the combined width when lut memory shares it
  function automatic logic mask_word(
    input bcm_kind_t kind,
    input logic [FW-1:0] frame,
    input logic lm_frame
  );
    int n_top;
    int n_bot;
    logic edge_hit;
    n_top = lut_memory_top ? COMBINED_FRAMES : IODRP_FRAMES;
    n_bot = lut_memory_bottom ? COMBINED_FRAMES : IODRP_FRAMES;
    edge_hit = (io_drp_top && (int'(frame) < n_top)) ||
      (io_drp_bottom && (int'(frame) >= NUM_FRAMES - n_bot));
    case (kind)
      KIND_BRAM: mask_word = 1'b1;
      KIND_PLL: mask_word = 1'b0;
      KIND_LUT: mask_word = lm_frame || edge_hit;
      KIND_IO: mask_word = edge_hit;
      default: mask_word = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // state and helper signals
  // ****************************************************************

  bcm_state_t state_q;
  logic released_q;
  logic golden_valid_q;
  logic [CRC_W-1:0] golden_q;
  logic [OSC_DIV_W-1:0] osc_cnt_q;
  logic osc_tick_q;
  logic mismatch_q;
  logic mismatch_d;
  logic halt_evt;
  logic may_run;
  logic bus_free;
  logic step_en;
  logic start_scan;
  logic last_word;
  logic capture_first;
  logic cmp_fail;
  logic [CRC_W-1:0] ref_crc;

  bcm_crc_if #(.DW(DW)) crc_ifc ();

  bcm_crc_engine #(.DW(DW)) u_engine (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .ifc(crc_ifc)
  );

  // ****************************************************************
  // run conditions
  // ****************************************************************

  // any of these abandons the scan and drops the flag
  assign halt_evt = sync_word_det || config_release_cmd || tap_reset ||
    config_abort || internal_reprogram_cmd || suspend_active ||
    shutdown_active;
  assign may_run = (readback_crc_enable == OPT_ENABLE) && done_pin &&
    released_q && !jtag_ir_config && !halt_evt;
  // reads only while nobody else wants the configuration bus
  assign bus_free = !jtag_bus_req && !user_config_busy;
  // step clock source: port clock wins, then pin or oscillator
  assign step_en = internal_config_port_present ? internal_config_port_clk_tick :
    (slave_mode ? config_clock_tick : osc_tick_q);
  assign start_scan = (state_q == ST_IDLE) && may_run && step_en;
  assign last_word = (rd_frame == LAST_FRAME) && (rd_word == LAST_WORD);

  // configuration logic is reachable only after a release word; a
  // new sync word means someone is configuring again
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      released_q <= 1'b0;
    end else if (ce) begin
      if (config_release_cmd) begin
        released_q <= 1'b1;
      end else if (sync_word_det) begin
        released_q <= 1'b0;
      end
    end
  end

  // internal oscillator modelled as a programmable divider
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_q <= '0;
      osc_tick_q <= 1'b0;
    end else if (ce) begin
      if (osc_cnt_q >= internal_osc_rate_select) begin
        osc_cnt_q <= '0;
        osc_tick_q <= 1'b1;
      end else begin
        osc_cnt_q <= osc_cnt_q + 1'b1;
        osc_tick_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // crc link
  // ****************************************************************

  assign crc_ifc.start = start_scan;
  assign crc_ifc.step = (state_q == ST_SCAN) && rd_req && rd_ack &&
    !mask_word(rd_kind, rd_frame, rd_lut_memory_frame);
  assign crc_ifc.data = rd_data;

  // ****************************************************************
  // comparison
  // ****************************************************************

  assign ref_crc = (golden_source_select == SRC_PRE_COMPUTED) ?
    precomputed_golden : golden_q;
  assign capture_first = (golden_source_select == SRC_FIRST_READBACK) &&
    !golden_valid_q;
  assign cmp_fail = (state_q == ST_CHECK) && may_run && !capture_first &&
    (crc_ifc.crc != ref_crc);

  // golden is forgotten on every halt, so it is reloaded or recaptured
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      golden_valid_q <= 1'b0;
      golden_q <= '0;
    end else if (ce) begin
      if (halt_evt) begin
        golden_valid_q <= 1'b0;
      end else if ((state_q == ST_CHECK) && may_run && !golden_valid_q) begin
        golden_valid_q <= 1'b1;
        golden_q <= (golden_source_select == SRC_FIRST_READBACK) ?
          crc_ifc.crc : precomputed_golden;
      end
    end
  end

  // ****************************************************************
  // sticky mismatch flag and pins
  // ****************************************************************

  // a mismatch in the same cycle as a user clear is kept
  always_comb begin
    mismatch_d = mismatch_q;
    if (halt_evt) begin
      mismatch_d = 1'b0;
    end else if (cmp_fail) begin
      mismatch_d = 1'b1;
    end else if (clear_error) begin
      mismatch_d = 1'b0;
    end
  end

  assign mismatch_q = crc_mismatch_out;

  // init pin only pulls low; done is left to the startup logic
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_mismatch_out <= 1'b0;
      init_pin_oe <= 1'b0;
      init_pin_o <= 1'b0;
    end else if (ce) begin
      crc_mismatch_out <= mismatch_d;
      init_pin_oe <= mismatch_d && done_pin &&
        (init_pin_flag_select == OPT_ENABLE);
      init_pin_o <= 1'b0;
    end
  end

  // ****************************************************************
  // scan sequencer
  // ****************************************************************

  // a pending read is withdrawn when the bus is taken; the word is
  // simply asked for again, so preemption costs only time
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      rd_req <= 1'b0;
      rd_frame <= '0;
      rd_word <= '0;
      checker_running <= 1'b0;
    end else if (ce) begin
      checker_running <= may_run && (state_q != ST_HOLD);
      case (state_q)
        ST_IDLE: begin
          rd_req <= 1'b0;
          if (start_scan) begin
            rd_frame <= '0;
            rd_word <= '0;
            state_q <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (!may_run) begin
            rd_req <= 1'b0;
            state_q <= ST_IDLE;
          end else if (rd_req && rd_ack) begin
            rd_req <= 1'b0;
            if (last_word) begin
              state_q <= ST_CHECK;
            end else if (rd_word == LAST_WORD) begin
              rd_word <= '0;
              rd_frame <= rd_frame + 1'b1;
            end else begin
              rd_word <= rd_word + 1'b1;
            end
          end else if (!bus_free) begin
            rd_req <= 1'b0;
          end else if (step_en) begin
            rd_req <= 1'b1;
          end
        end
        ST_CHECK: begin
          if (cmp_fail && (error_action_select == ACT_HALT)) begin
            state_q <= ST_HOLD;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!mismatch_d) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          rd_req <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  chk_flag_sticky: assert property (
    crc_mismatch_out && !(ce && (clear_error || halt_evt)) |=>
      crc_mismatch_out)
    else $error("mismatch flag dropped without a clear");

  chk_halt_clears: assert property (
    ce && halt_evt |=> !crc_mismatch_out && state_q == ST_IDLE &&
      !rd_req && !golden_valid_q)
    else $error("halt event did not stop and clear");

  chk_flag_pins: assert property (
    ce && cmp_fail && done_pin && init_pin_flag_select |=>
      crc_mismatch_out && init_pin_oe && !init_pin_o)
    else $error("mismatch not shown on flag and init pin");

  chk_init_disable: assert property (
    ce && !init_pin_flag_select |=> !init_pin_oe)
    else $error("init pin driven while disabled");

  chk_compare_end: assert property (
    state_q == ST_CHECK && ce && may_run && golden_valid_q &&
      crc_ifc.crc != ref_crc |=> crc_mismatch_out)
    else $error("scan crc differs but no mismatch");

  chk_jtag_ir: assert property (
    ce && jtag_ir_config |=> !rd_req ##1 !rd_req || jtag_ir_config)
    else $error("readback while jtag holds config instruction");

  chk_bus_yield: assert property (
    ce && (jtag_bus_req || user_config_busy) |=> !rd_req)
    else $error("readback request while bus taken");

  // a held error stays held while done is low; only reading is barred
  chk_need_done: assert property (
    ce && !done_pin |=> (state_q == ST_IDLE || state_q == ST_HOLD) &&
      !rd_req && !checker_running)
    else $error("checker active before done");

  chk_bram_skip: assert property (
    ce && state_q == ST_SCAN && rd_req && rd_ack &&
      rd_kind == KIND_BRAM |=> crc_ifc.crc == $past(crc_ifc.crc))
    else $error("block ram word entered crc");

  chk_pll_kept: assert property (
    state_q == ST_SCAN && rd_req && rd_ack && rd_kind == KIND_PLL |->
      crc_ifc.step)
    else $error("pll word masked");

  chk_scan_seed: assert property (
    ce && start_scan |=> crc_ifc.crc == CRC_INIT && state_q == ST_SCAN)
    else $error("scan not reseeded");

  chk_halt_action: assert property (
    ce && cmp_fail && error_action_select == ACT_HALT |=>
      state_q == ST_HOLD && !rd_req)
    else $error("halt action did not stop checking");

  chk_first_golden: assert property (
    ce && state_q == ST_CHECK && may_run && capture_first |=>
      golden_valid_q && golden_q == $past(crc_ifc.crc) &&
      !crc_mismatch_out || $past(crc_mismatch_out))
    else $error("first readback golden not captured");

  cov_scan_pass: cover property (
    state_q == ST_CHECK && may_run && !cmp_fail);
  cov_mismatch: cover property (ce && cmp_fail);
  cov_preempt: cover property (rd_req ##1 jtag_bus_req);

endmodule

// *** bench/bcm_mem_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// configuration memory seen from the readback port
// ****************************************************************
module bcm_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // readback port
  input wire logic rd_req,
  input wire logic [2:0] rd_frame,
  input wire logic [0:0] rd_word,
  output logic rd_ack,
  output logic [31:0] rd_data,
  output bcm_pkg::bcm_kind_t rd_kind,
  output logic rd_lut_memory_frame,
  // upset injection and pacing
  input wire logic upset_en,
  input wire logic [4:0] upset_word,
  input wire logic slow
);
  import bcm_pkg::*;
  logic [1:0] wait_q;
  logic [4:0] idx;
  logic [31:0] val;
  bcm_kind_t kind_c;

  // frame map: 0 io, 2 block ram, 3 lut memory, 5 pll, odd words other
  assign idx = {1'b0, rd_frame, rd_word};
  assign kind_c = idx[0] ? KIND_OTHER : rd_frame == 3'h0 ? KIND_IO :
    rd_frame == 3'h2 ? KIND_BRAM : rd_frame == 3'h5 ? KIND_PLL : KIND_LUT;
  assign val = (32'h5a3c0000 | {16'h0, 3'h0, idx, 3'h0, idx}) ^
    ((upset_en && idx == upset_word) ? 32'h00000100 : 32'h0);

  // one ack per request; slow mode stalls three cycles first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 2'h0;
      rd_ack <= 1'b0;
    end else if (rd_req && !rd_ack) begin
      wait_q <= wait_q + 2'h1;
      rd_ack <= !slow || wait_q == 2'h3;
    end else begin
      wait_q <= 2'h0;
      rd_ack <= 1'b0;
    end
  end

  // data only holds meaning with the ack; otherwise it keeps moving
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 32'h0;
      rd_kind <= KIND_OTHER;
      rd_lut_memory_frame <= 1'b0;
    end else begin
      rd_data <= rd_req ? val : ~rd_data;
      rd_kind <= kind_c;
      rd_lut_memory_frame <= rd_req ? rd_frame == 3'h3 : !rd_lut_memory_frame;
    end
  end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import bcm_pkg::*;
  typedef struct packed {
    logic [3:0] msk;
    logic up;
    logic [4:0] w;
    logic [1:0] src;
    logic slow;
    logic exp;
  } bcm_row_t;
  logic core_clk, arst_n, ce, readback_crc_enable, init_pin_flag_select;
  logic error_action_select, golden_source_select, slave_mode;
  logic [OSC_DIV_W-1:0] internal_osc_rate_select;
  logic [CRC_W-1:0] precomputed_golden;
  logic internal_config_port_present, internal_config_port_clk_tick, config_clock_tick;
  logic done_pin, config_release_cmd, jtag_ir_config, jtag_bus_req;
  logic user_config_busy, clear_error, io_drp_top, io_drp_bottom;
  logic lut_memory_top, lut_memory_bottom, sync_word_det, tap_reset;
  logic config_abort, internal_reprogram_cmd, suspend_active;
  logic shutdown_active, rd_req, rd_ack, rd_lut_memory_frame;
  logic [2:0] rd_frame;
  logic [0:0] rd_word;
  logic [31:0] rd_data;
  bcm_kind_t rd_kind;
  logic crc_mismatch_out, checker_running, init_pin_o, init_pin_oe;
  logic [5:0] evt;
  logic upset_en, slow, internal_config_port_on, config_clock_pin_on;
  logic [4:0] upset_word;
  logic [7:0] cyc_q;
  int n_errors, checks;
  // masks {top,bot,lutmem top,lutmem bot}; src 0 port, 1 pin, 2 osc
  localparam bcm_row_t ROWS[10] = '{
    {4'h0, 1'h0, 5'h00, 2'h0, 1'h0, 1'h0},
    {4'h0, 1'h1, 5'h04, 2'h1, 1'h0, 1'h0},
    {4'h0, 1'h1, 5'h06, 2'h2, 1'h1, 1'h0},
    {4'h5, 1'h1, 5'h0a, 2'h0, 1'h0, 1'h1},
    {4'h8, 1'h1, 5'h00, 2'h1, 1'h0, 1'h0},
    {4'ha, 1'h1, 5'h08, 2'h0, 1'h0, 1'h0},
    {4'h8, 1'h1, 5'h08, 2'h2, 1'h0, 1'h1},
    {4'h4, 1'h1, 5'h0e, 2'h0, 1'h1, 1'h0},
    {4'h5, 1'h1, 5'h08, 2'h1, 1'h0, 1'h0},
    {4'h0, 1'h1, 5'h02, 2'h1, 1'h1, 1'h1}};

  // halting events other than the release command share one vector so loops can walk them
  assign {shutdown_active, suspend_active, internal_reprogram_cmd,
    config_abort, tap_reset, sync_word_det} = evt;

  bcm_monitor #(.NUM_FRAMES(8), .WORDS(2)) dut_u (.core_clk, .arst_n, .ce,
    .readback_crc_enable, .init_pin_flag_select, .error_action_select,
    .golden_source_select, .internal_osc_rate_select, .precomputed_golden,
    .internal_config_port_present, .slave_mode, .internal_config_port_clk_tick,
    .config_clock_tick, .done_pin, .sync_word_det, .config_release_cmd,
    .tap_reset, .config_abort, .internal_reprogram_cmd, .suspend_active,
    .shutdown_active, .jtag_ir_config, .jtag_bus_req, .user_config_busy,
    .io_drp_top, .io_drp_bottom, .lut_memory_top, .lut_memory_bottom,
    .rd_req, .rd_frame, .rd_word, .rd_ack, .rd_data, .rd_kind,
    .rd_lut_memory_frame, .clear_error, .crc_mismatch_out, .checker_running,
    .init_pin_o, .init_pin_oe);

  bcm_mem_model mem_u (.core_clk, .arst_n, .rd_req, .rd_frame, .rd_word,
    .rd_ack, .rd_data, .rd_kind, .rd_lut_memory_frame, .upset_en,
    .upset_word, .slow);

  // ****************************************************************
  // clock, pacing strobes and helpers
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // port clock every 2nd cycle, pin clock every 3rd, off when stopped
  always @(posedge core_clk) begin
    #1;
    cyc_q = cyc_q + 8'h01;
    internal_config_port_clk_tick = internal_config_port_on && cyc_q[0];
    config_clock_tick = config_clock_pin_on && cyc_q % 3 == 0;
  end

  task automatic cyc();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", what, e, g);
      n_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // 0 request seen, 1 last word acked, 2 flag raised; bounded
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (!(sel == 0 ? rd_req === 1'b1 : sel == 1 ? (rd_ack === 1'b1 &&
        rd_frame === 3'h7 && rd_word === 1'h1) : crc_mismatch_out === 1'b1))
    begin
      cyc();
      n++;
      if (n > 3000) begin
        $display("unexpected wait %0d: expected event, seen timeout", sel);
        n_errors++;
        stop_test();
      end
    end
  endtask

  // run: checker_running level expected while no read may be issued
  task automatic watch_idle(input int n, input logic run);
    int hits;
    hits = 0;
    repeat (n) begin
      cyc();
      if (rd_req !== 1'b0 || checker_running !== run) hits++;
    end
    chk("busy cycles", 32'h0, hits);
  endtask

  // reference crc: msb first, no final inversion
  function automatic logic [31:0] crc_step(logic [31:0] c, logic [31:0] d);
    for (int i = 31; i >= 0; i--)
      c = (c << 1) ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction

  function automatic logic skipped(logic [4:0] k);
    int nt, nb;
    nt = io_drp_top ? (lut_memory_top ? COMBINED_FRAMES : 1) : 0;
    nb = io_drp_bottom ? (lut_memory_bottom ? COMBINED_FRAMES : 1) : 0;
    if (k[0] || k[4:1] == 4'h5) return 1'b0;
    if (k[4:1] == 4'h2 || k[4:1] == 4'h3) return 1'b1;
    return k[4:1] < nt || k[4:1] >= 8 - nb;
  endfunction

  // golden over unmasked words of the clean memory image
  function automatic logic [31:0] golden();
    logic [31:0] c;
    c = CRC_INIT;
    for (int k = 0; k < 16; k++)
      if (!skipped(5'(k)))
        c = crc_step(c, 32'h5a3c0000 | {16'h0, 3'h0, 5'(k), 3'h0, 5'(k)});
    return c;
  endfunction

  task automatic base();
    readback_crc_enable = OPT_ENABLE;
    init_pin_flag_select = 1'b1;
    error_action_select = ACT_HALT;
    golden_source_select = SRC_PRE_COMPUTED;
    {internal_config_port_present, slave_mode, internal_config_port_on, config_clock_pin_on} = 4'hb;
    {done_pin, jtag_ir_config, jtag_bus_req, user_config_busy} = 4'h8;
    {io_drp_top, io_drp_bottom, lut_memory_top, lut_memory_bottom} = 4'h0;
    {evt, upset_en, slow, clear_error} = 9'h000;
    upset_word = 5'h0f;
  endtask

  task automatic rel();
    precomputed_golden = golden();
    config_release_cmd = 1'b1;
    cyc();
    config_release_cmd = 1'b0;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {arst_n, ce, config_release_cmd, internal_config_port_clk_tick} = 4'h4;
    {config_clock_tick, cyc_q, precomputed_golden} = 41'h0;
    internal_osc_rate_select = 8'h03;
    base();
    repeat (12) @(posedge core_clk);
    #1;
    chk("outputs in reset", 5'h00, {rd_req, crc_mismatch_out,
      checker_running, init_pin_o, init_pin_oe});
    arst_n = 1'b1;
    watch_idle(30, 1'b0);
    // masking and clock source cases, two scans each
    foreach (ROWS[i]) begin
      base();
      {io_drp_top, io_drp_bottom, lut_memory_top, lut_memory_bottom} =
        ROWS[i].msk;
      {upset_en, upset_word, slow} = {ROWS[i].up, ROWS[i].w, ROWS[i].slow};
      internal_config_port_present = ROWS[i].src == 2'h0;
      slave_mode = ROWS[i].src == 2'h1;
      error_action_select = ACT_CONTINUE;
      rel();
      cyc();
      chk("flag after release", 1'h0, crc_mismatch_out);
      wait_for(1);
      repeat (4) cyc();
      chk("flag", ROWS[i].exp, crc_mismatch_out);
      chk("init pin", ROWS[i].exp, init_pin_oe);
      wait_for(1);
      repeat (4) cyc();
      chk("second scan", ROWS[i].exp, crc_mismatch_out);
    end
    // run conditions, bus access or pacing removed in the middle of a scan
    for (int b = 0; b < 8; b++) begin
      base();
      rel();
      wait_for(0);
      case (b)
        0: readback_crc_enable = OPT_DISABLE;
        1: done_pin = 1'b0;
        2: jtag_ir_config = 1'b1;
        3: jtag_bus_req = 1'b1;
        4: user_config_busy = 1'b1;
        5: evt[4] = 1'b1;
        6: internal_config_port_on = 1'b0;
        default: evt[0] = 1'b1;
      endcase
      repeat (4) cyc();
      evt[0] = 1'b0;
      // bus taken or pacing stopped: run conditions still met
      watch_idle(60, b inside {3, 4, 6});
    end
    // each of the six halting events in evt clears a raised flag; the release command is not walked here
    for (int e = 0; e < 6; e++) begin
      base();
      error_action_select = ACT_CONTINUE;
      upset_en = 1'b1;
      rel();
      wait_for(2);
      evt[e] = 1'b1;
      cyc();
      evt[e] = 1'b0;
      cyc();
      chk("flag after halt", 2'h0, {crc_mismatch_out, init_pin_oe});
    end
    // halt action, then clear from user logic and resume
    base();
    upset_en = 1'b1;
    rel();
    wait_for(2);
    cyc();
    chk("init pin drive", 2'h1, {init_pin_o, init_pin_oe});
    watch_idle(60, 1'b0);
    clear_error = 1'b1;
    cyc();
    clear_error = 1'b0;
    cyc();
    chk("flag after clear", 1'h0, crc_mismatch_out);
    wait_for(0);
    // init pin not used as indicator
    base();
    init_pin_flag_select = 1'b0;
    upset_en = 1'b1;
    rel();
    wait_for(2);
    cyc();
    chk("init pin disabled", 1'h0, init_pin_oe);
    // golden taken from the first scan, tool value ignored
    base();
    golden_source_select = SRC_FIRST_READBACK;
    error_action_select = ACT_CONTINUE;
    rel();
    precomputed_golden = ~precomputed_golden;
    wait_for(1);
    cyc();
    wait_for(1);
    repeat (4) cyc();
    chk("first readback", 1'h0, crc_mismatch_out);
    upset_en = 1'b1;
    wait_for(1);
    repeat (4) cyc();
    chk("upset after capture", 1'h1, crc_mismatch_out);
    // clock enable low freezes a pending read, then reset in mid-run
    base();
    rel();
    wait_for(0);
    ce = 1'b0;
    repeat (20) cyc();
    chk("frozen read", 5'h10, {rd_req, rd_frame, rd_word});
    ce = 1'b1;
    repeat (4) cyc();
    arst_n = 1'b0;
    cyc();
    chk("outputs in mid reset", 5'h00, {rd_req, crc_mismatch_out,
      checker_running, init_pin_o, init_pin_oe});
    arst_n = 1'b1;
    watch_idle(30, 1'b0);
    stop_test();
  end
endmodule
